// *** design/cdsr_regs.sv ***
// clock delay, filter and multi-chip sync register bank
`timescale 1ns/1ps
module cdsr_regs (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic        WR_EN,
  input  wire logic        RD_EN,
  input  wire logic [3:0]  ADDR,
  input  wire logic [15:0] WDATA,
  output logic      [15:0] RDATA,
  output logic      [11:0] COARSE_DELAY,
  output logic      [5:0]  FINE_DELAY,
  output logic      [12:0] TOTAL_DELAY,
  output logic             APERTURE_EN,
  output logic             FILTER_EN,
  output logic      [7:0]  TANK_FILTER_TUNE,
  output logic             DUTY_CYCLE_CORRECT_EN,
  output logic      [9:0]  REF_CLOCK_DELAY,
  output logic      [1:0]  REF_PHASE_SELECT,
  output logic             SLAVE_ENABLE,
  output logic             REF_CLOCK_OUT_A,
  output logic             REF_CLOCK_OUT_B,
  output logic             OUTPUT_CLOCK_RESET_EN,
  input  wire logic        OUTPUT_CLOCK_RESET_PIN,
  output logic             OUTPUT_CLOCK_RESET
);
  logic [15:0] coarse_reg;
  logic [15:0] fine_reg;
  logic [15:0] sync_reg;
  logic [11:0] coarse_code;
  logic [5:0]  fine_code;
  logic [9:0]  refd_code;
  logic        aper_on;
  logic        div4;
  logic        pin_meta_reg;
  logic        pin_sync_reg;

  assign coarse_code = coarse_reg[cdsr_pkg::COARSE_LSB +: cdsr_pkg::COARSE_W];
  assign fine_code   = fine_reg[cdsr_pkg::FINE_LSB +: cdsr_pkg::FINE_W];
  assign refd_code   = sync_reg[cdsr_pkg::REFD_LSB +: cdsr_pkg::REFD_W];
  // filter select alone is enough; then aperture select is don't-care
  assign aper_on = fine_reg[cdsr_pkg::FILT_SEL_BIT] | coarse_reg[cdsr_pkg::APER_SEL_BIT];

  // reserved bits are masked so they always read back zero
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      coarse_reg <= cdsr_pkg::RST_COARSE;
    end else if (WR_EN && ADDR == cdsr_pkg::ADDR_COARSE) begin
      coarse_reg <= WDATA & cdsr_pkg::MASK_COARSE;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      fine_reg <= cdsr_pkg::RST_FINE;
    end else if (WR_EN && ADDR == cdsr_pkg::ADDR_FINE) begin
      fine_reg <= WDATA & cdsr_pkg::MASK_FINE;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      sync_reg <= cdsr_pkg::RST_SYNC;
    end else if (WR_EN && ADDR == cdsr_pkg::ADDR_SYNC) begin
      sync_reg <= WDATA & cdsr_pkg::MASK_SYNC;
    end
  end

  // read data registered; unmapped addresses read zero
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      RDATA <= 16'h0000;
    end else if (RD_EN) begin
      unique case (ADDR)
        cdsr_pkg::ADDR_COARSE: RDATA <= coarse_reg;
        cdsr_pkg::ADDR_FINE:   RDATA <= fine_reg;
        cdsr_pkg::ADDR_SYNC:   RDATA <= sync_reg;
        default:               RDATA <= 16'h0000;
      endcase
    end
  end

  // delay controls, coarse code saturated, all gated by the select bits
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      COARSE_DELAY <= 12'h000;
      FINE_DELAY   <= 6'h00;
      TOTAL_DELAY  <= 13'h0000;
      APERTURE_EN  <= 1'b0;
      FILTER_EN    <= 1'b0;
    end else begin
      APERTURE_EN <= aper_on;
      FILTER_EN   <= fine_reg[cdsr_pkg::FILT_SEL_BIT];
      if (aper_on) begin
        COARSE_DELAY <= (coarse_code > cdsr_pkg::COARSE_MAX) ? cdsr_pkg::COARSE_MAX : coarse_code;
        FINE_DELAY   <= fine_code;
        TOTAL_DELAY  <= {1'b0, ((coarse_code > cdsr_pkg::COARSE_MAX) ? cdsr_pkg::COARSE_MAX : coarse_code)}
                        + {7'h00, fine_code};
      end else begin
        COARSE_DELAY <= 12'h000;
        FINE_DELAY   <= 6'h00;
        TOTAL_DELAY  <= 13'h0000;
      end
    end
  end

  // thermometer tune passed unchanged; analog tank decodes the bit count
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      TANK_FILTER_TUNE      <= 8'h00;
      DUTY_CYCLE_CORRECT_EN <= 1'b1;
    end else begin
      TANK_FILTER_TUNE      <= fine_reg[cdsr_pkg::TUNE_LSB +: cdsr_pkg::TUNE_W];
      DUTY_CYCLE_CORRECT_EN <= coarse_reg[cdsr_pkg::DCC_BIT];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      REF_CLOCK_DELAY  <= 10'h000;
      REF_PHASE_SELECT <= 2'h0;
      SLAVE_ENABLE     <= 1'b0;
    end else begin
      REF_CLOCK_DELAY  <= (refd_code > cdsr_pkg::REFD_MAX) ? cdsr_pkg::REFD_MAX : refd_code;
      REF_PHASE_SELECT <= sync_reg[cdsr_pkg::PHASE_LSB +: 2];
      SLAVE_ENABLE     <= sync_reg[cdsr_pkg::SLAVE_BIT];
    end
  end

  // output enable ignores the slave bit on purpose
  cdsr_div4 u_div4 (
    .clk      (SYS_CLK),
    .rst      (RST),
    .en       (!sync_reg[cdsr_pkg::OUTDIS_BIT]),
    .clk_div4 (div4)
  );

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      REF_CLOCK_OUT_A <= 1'b0;
      REF_CLOCK_OUT_B <= 1'b0;
    end else begin
      REF_CLOCK_OUT_A <= div4;
      REF_CLOCK_OUT_B <= div4;
    end
  end

  // reset pin is asynchronous to us: two flops before use
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
    end else begin
      pin_meta_reg <= OUTPUT_CLOCK_RESET_PIN;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      OUTPUT_CLOCK_RESET_EN <= 1'b0;
      OUTPUT_CLOCK_RESET    <= 1'b0;
    end else begin
      OUTPUT_CLOCK_RESET_EN <= !sync_reg[cdsr_pkg::RSTDIS_BIT];
      OUTPUT_CLOCK_RESET    <= !sync_reg[cdsr_pkg::RSTDIS_BIT] && pin_sync_reg;
    end
  end

  a_coarse_sat: assert property (@(posedge SYS_CLK) disable iff (RST)
    (aper_on && coarse_code > cdsr_pkg::COARSE_MAX) |=> COARSE_DELAY == cdsr_pkg::COARSE_MAX)
    else $error("coarse delay not saturated");
  a_coarse_pass: assert property (@(posedge SYS_CLK) disable iff (RST)
    (aper_on && coarse_code <= cdsr_pkg::COARSE_MAX) |=> COARSE_DELAY == $past(coarse_code))
    else $error("coarse delay not linear");
  a_delay_gated: assert property (@(posedge SYS_CLK) disable iff (RST)
    !aper_on |=> (COARSE_DELAY == 12'h000 && FINE_DELAY == 6'h00))
    else $error("delay applied while disabled");
  a_filt_overrides: assert property (@(posedge SYS_CLK) disable iff (RST)
    fine_reg[cdsr_pkg::FILT_SEL_BIT] |=> (APERTURE_EN && FILTER_EN))
    else $error("filter select did not enable aperture");
  a_fine_applied: assert property (@(posedge SYS_CLK) disable iff (RST)
    coarse_reg[cdsr_pkg::APER_SEL_BIT] |=> FINE_DELAY == $past(fine_code))
    else $error("fine delay not applied");
  a_total_sum: assert property (@(posedge SYS_CLK) disable iff (RST)
    APERTURE_EN |-> TOTAL_DELAY == {1'b0, COARSE_DELAY} + {7'h00, FINE_DELAY})
    else $error("total delay not the sum");
  a_refd_sat: assert property (@(posedge SYS_CLK) disable iff (RST)
    refd_code >= cdsr_pkg::REFD_MAX |=> REF_CLOCK_DELAY == cdsr_pkg::REFD_MAX)
    else $error("reference delay not saturated");
  a_refout_off: assert property (@(posedge SYS_CLK) disable iff (RST)
    sync_reg[cdsr_pkg::OUTDIS_BIT] [*3] |=> (!REF_CLOCK_OUT_A && !REF_CLOCK_OUT_B))
    else $error("reference outputs active while disabled");
  a_refout_toggle: assert property (@(posedge SYS_CLK) disable iff (RST)
    (!sync_reg[cdsr_pkg::OUTDIS_BIT] [*8]) |-> (REF_CLOCK_OUT_A != $past(REF_CLOCK_OUT_A, 2)))
    else $error("reference output not clk/4");
  a_rst_gate: assert property (@(posedge SYS_CLK) disable iff (RST)
    sync_reg[cdsr_pkg::RSTDIS_BIT] |=> !OUTPUT_CLOCK_RESET)
    else $error("data clock reset while disabled");
  a_dcc_follow: assert property (@(posedge SYS_CLK) disable iff (RST)
    ##1 DUTY_CYCLE_CORRECT_EN == $past(coarse_reg[cdsr_pkg::DCC_BIT]))
    else $error("duty cycle enable wrong");

  // one-edge follow checks for the delay, filter and sync controls plus a same-edge coarse delay bound, not the reference clock outputs
  a_fine_pass: assert property (@(posedge SYS_CLK) disable iff (RST)
    aper_on |=> FINE_DELAY == $past(fine_code))
    else $error("fine delay not passed");

  a_total_off: assert property (@(posedge SYS_CLK) disable iff (RST)
    !aper_on |=> TOTAL_DELAY == 13'h0000)
    else $error("total delay applied while disabled");

  a_aper_follow: assert property (@(posedge SYS_CLK) disable iff (RST)
    1'b1 |=> APERTURE_EN == $past(aper_on))
    else $error("aperture enable wrong");

  a_filter_follow: assert property (@(posedge SYS_CLK) disable iff (RST)
    1'b1 |=> FILTER_EN == $past(fine_reg[cdsr_pkg::FILT_SEL_BIT]))
    else $error("filter enable wrong");

  a_tune_follow: assert property (@(posedge SYS_CLK) disable iff (RST)
    1'b1 |=> TANK_FILTER_TUNE == $past(fine_reg[cdsr_pkg::TUNE_LSB +: cdsr_pkg::TUNE_W]))
    else $error("filter tune not passed");

  a_phase_follow: assert property (@(posedge SYS_CLK) disable iff (RST)
    1'b1 |=> REF_PHASE_SELECT == $past(sync_reg[cdsr_pkg::PHASE_LSB +: 2]))
    else $error("phase select wrong");

  a_slave_follow: assert property (@(posedge SYS_CLK) disable iff (RST)
    1'b1 |=> SLAVE_ENABLE == $past(sync_reg[cdsr_pkg::SLAVE_BIT]))
    else $error("slave enable wrong");

  a_refd_pass: assert property (@(posedge SYS_CLK) disable iff (RST)
    refd_code < cdsr_pkg::REFD_MAX |=> REF_CLOCK_DELAY == $past(refd_code))
    else $error("reference delay not linear");

  a_coarse_max: assert property (@(posedge SYS_CLK) disable iff (RST)
    COARSE_DELAY <= cdsr_pkg::COARSE_MAX)
    else $error("coarse delay above maximum");

  // both drivers come from one divider, so they never part
  a_refout_pair: assert property (@(posedge SYS_CLK) disable iff (RST)
    REF_CLOCK_OUT_A == REF_CLOCK_OUT_B)
    else $error("reference outputs differ");

  a_div4_off: assert property (@(posedge SYS_CLK) disable iff (RST)
    sync_reg[cdsr_pkg::OUTDIS_BIT] |=> !div4)
    else $error("divider running while disabled");

  a_rsv_coarse: assert property (@(posedge SYS_CLK) disable iff (RST)
    (coarse_reg & ~cdsr_pkg::MASK_COARSE) == 16'h0000)
    else $error("coarse reserved bits set");

  a_rsv_fine: assert property (@(posedge SYS_CLK) disable iff (RST)
    (fine_reg & ~cdsr_pkg::MASK_FINE) == 16'h0000)
    else $error("fine reserved bit set");

  a_rsv_sync: assert property (@(posedge SYS_CLK) disable iff (RST)
    (sync_reg & ~cdsr_pkg::MASK_SYNC) == 16'h0000)
    else $error("sync reserved bit set");

  a_ocr_en_follow: assert property (@(posedge SYS_CLK) disable iff (RST)
    1'b1 |=> OUTPUT_CLOCK_RESET_EN == $past(!sync_reg[cdsr_pkg::RSTDIS_BIT]))
    else $error("data clock reset enable wrong");

  a_ocr_follow: assert property (@(posedge SYS_CLK) disable iff (RST)
    1'b1 |=> OUTPUT_CLOCK_RESET == ($past(!sync_reg[cdsr_pkg::RSTDIS_BIT]) && $past(pin_sync_reg)))
    else $error("data clock reset not gated pin");

  // read data must not move between reads
  a_rdata_hold: assert property (@(posedge SYS_CLK) disable iff (RST)
    !RD_EN |=> $stable(RDATA))
    else $error("read data changed without read");
endmodule

// *** common/cdsr_pkg.sv ***
// constants for the clock delay and sync register bank
package cdsr_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] ADDR_COARSE = 4'hc;
  localparam logic [3:0] ADDR_FINE   = 4'hd;
  localparam logic [3:0] ADDR_SYNC   = 4'he;
  localparam logic [15:0] RST_COARSE = 16'h0004;
  localparam logic [15:0] RST_FINE   = 16'h0000;
  localparam logic [15:0] RST_SYNC   = 16'h0003;
  // writable bit masks; reserved bits read zero
  localparam logic [15:0] MASK_COARSE = 16'hfffc;
  localparam logic [15:0] MASK_FINE   = 16'hfdff;
  localparam logic [15:0] MASK_SYNC   = 16'hffdf;
  localparam int COARSE_LSB = 4;
  localparam int COARSE_W   = 12;
  localparam int APER_SEL_BIT = 3;
  localparam int DCC_BIT      = 2;
  localparam int FINE_LSB     = 10;
  localparam int FINE_W       = 6;
  localparam int FILT_SEL_BIT = 8;
  localparam int TUNE_LSB     = 0;
  localparam int TUNE_W       = 8;
  localparam int REFD_LSB     = 6;
  localparam int REFD_W       = 10;
  localparam int PHASE_LSB    = 3;
  localparam int SLAVE_BIT    = 2;
  localparam int OUTDIS_BIT   = 1;
  localparam int RSTDIS_BIT   = 0;
  localparam logic [11:0] COARSE_MAX = 12'h97f;
  localparam logic [9:0]  REFD_MAX   = 10'h27f;
  localparam logic [1:0]  DIV4_LAST  = 2'h3;
endpackage

// *** design/cdsr_div4.sv ***
// divide-by-four reference clock generator
`timescale 1ns/1ps
module cdsr_div4 (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       en,
  output logic            clk_div4
);
  logic [1:0] cnt_reg;

  always_ff @(posedge clk) begin
    if (rst || !en) begin
      cnt_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end

  // msb of a 2-bit counter toggles every two cycles: period of four
  always_ff @(posedge clk) begin
    if (rst || !en) begin
      clk_div4 <= 1'b0;
    end else begin
      clk_div4 <= (cnt_reg + 2'h1) >= 2'h2;
    end
  end
endmodule

// *** dv/clock_delay_sync_regs_bench.sv ***
// self-checking bench for the clock delay and sync register bank
`timescale 1ns/1ps
module clock_delay_sync_regs_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        pin = 1'b0;
  logic [15:0] rdata;
  logic [11:0] coarse;
  logic [5:0]  fine;
  logic [12:0] total;
  logic        aper_en;
  logic        filt_en;
  logic [7:0]  tune;
  logic        dcc;
  logic [9:0]  refd;
  logic [1:0]  phase;
  logic        slave;
  logic        ref_a;
  logic        ref_b;
  logic        ocr_en;
  logic        ocr;
  int          n_mismatch = 0;
  int          check_count = 0;

  always #2.5 clk = ~clk;

  cdsr_regs dut_u (.SYS_CLK(clk), .RST(rst), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr), .WDATA(wdata),
    .RDATA(rdata), .COARSE_DELAY(coarse), .FINE_DELAY(fine), .TOTAL_DELAY(total), .APERTURE_EN(aper_en),
    .FILTER_EN(filt_en), .TANK_FILTER_TUNE(tune), .DUTY_CYCLE_CORRECT_EN(dcc), .REF_CLOCK_DELAY(refd),
    .REF_PHASE_SELECT(phase), .SLAVE_ENABLE(slave), .REF_CLOCK_OUT_A(ref_a), .REF_CLOCK_OUT_B(ref_b),
    .OUTPUT_CLOCK_RESET_EN(ocr_en), .OUTPUT_CLOCK_RESET_PIN(pin), .OUTPUT_CLOCK_RESET(ocr));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  // leaves two spare edges so derived outputs have settled
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk); #1;
    wr_en = 1'b1; addr = a; wdata = d;
    @(posedge clk); #1;
    wr_en = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk); #1;
    rd_en = 1'b1; addr = a;
    @(posedge clk); #1;
    rd_en = 1'b0;
    chk("rdata", exp, rdata);
  endtask

  task automatic delays(input int c, input int f, input logic ae, input logic fe);
    chk("coarse", 16'(c), {4'h0, coarse});
    chk("fine", 16'(f), {10'h0, fine});
    chk("total", 16'(c + f), {3'h0, total});
    chk("aper_en", {15'h0, ae}, {15'h0, aper_en});
    chk("filt_en", {15'h0, fe}, {15'h0, filt_en});
  endtask

  // counts rising edges of both reference outputs over 16 cycles
  task automatic ref_clk(input int exp);
    int ra;
    int rb;
    logic pa;
    logic pb;
    ra = 0; rb = 0; pa = ref_a; pb = ref_b;
    repeat (16) begin
      @(posedge clk); #1;
      if (ref_a === 1'b1 && pa === 1'b0) ra++;
      if (ref_b === 1'b1 && pb === 1'b0) rb++;
      pa = ref_a; pb = ref_b;
    end
    chk("ref_a_rises", 16'(exp), 16'(ra));
    chk("ref_b_rises", 16'(exp), 16'(rb));
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    int codes[4] = '{2431, 2432, 4095, 0};
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    rd(4'hc, 16'h0004); rd(4'hd, 16'h0000); rd(4'he, 16'h0003); rd(4'h3, 16'h0000);
    chk("dcc", 16'h0001, {15'h0, dcc});
    chk("ocr_en", 16'h0000, {15'h0, ocr_en});
    ref_clk(0);
    $display("test reset done");
    foreach (codes[i]) begin
      wr(4'hc, {12'(codes[i]), 4'b1011});
      rd(4'hc, {12'(codes[i]), 4'b1000});
      delays(codes[i] > 2431 ? 2431 : codes[i], 0, 1'b1, 1'b0);
      chk("dcc_off", 16'h0000, {15'h0, dcc});
    end
    wr(4'hc, {12'd100, 4'b0100});
    delays(0, 0, 1'b0, 1'b0);
    wr(4'hd, {6'd63, 2'b11, 8'h0f});
    rd(4'hd, {6'd63, 2'b01, 8'h0f});
    delays(100, 63, 1'b1, 1'b1);
    chk("tune", 16'h000f, {8'h0, tune});
    wr(4'hc, {12'd2431, 4'b1100});
    delays(2431, 63, 1'b1, 1'b1);
    wr(4'hd, {6'd5, 2'b00, 8'hff});
    delays(2431, 5, 1'b1, 1'b0);
    chk("tune", 16'h00ff, {8'h0, tune});
    wr(4'hc, 16'h0004);
    delays(0, 0, 1'b0, 1'b0);
    $display("test delay done");
    for (int p = 0; p < 4; p++) begin
      wr(4'he, {10'd638, 1'b1, 2'(p), 3'b111});
      rd(4'he, {10'd638, 1'b0, 2'(p), 3'b111});
      chk("phase", 16'(p), {14'h0, phase});
      chk("refd", 16'd638, {6'h0, refd});
      chk("slave", 16'h0001, {15'h0, slave});
    end
    wr(4'he, 16'hffc0);
    chk("refd_sat", 16'd639, {6'h0, refd});
    chk("slave", 16'h0000, {15'h0, slave});
    ref_clk(4);
    chk("ocr_en", 16'h0001, {15'h0, ocr_en});
    pin = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("ocr", 16'h0001, {15'h0, ocr});
    wr(4'he, {10'd639, 6'b000101});
    ref_clk(4);
    chk("ocr_off", 16'h0000, {15'h0, ocr});
    wr(4'he, 16'h0003);
    ref_clk(0);
    $display("test sync done");
    tally_and_finish();
  end
endmodule
